// *** lsc_defs.svh ***
// Offsets, fields, reset values and timing of the line supervision block
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

// Register indices; byte address is four times the index
`define LSC_IDX_LFD        10'h040
`define LSC_IDX_AMC        10'h043
`define LSC_IDX_DET        10'h044
`define LSC_IDX_LCD        10'h045
`define LSC_IDX_RTD        10'h046
`define LSC_IDX_LOOP_CURRENT_SETTING       10'h047
`define LSC_IDX_OHV        10'h048
`define LSC_IDX_CMV        10'h049

// Reset values
`define LSC_RST_LFD        8'h00
`define LSC_RST_AMC        8'h00
`define LSC_RST_DET        8'h00
`define LSC_RST_LCD        8'h0A
`define LSC_RST_RTD        8'h0A
`define LSC_RST_LOOP_CURRENT_SETTING       8'h00
`define LSC_RST_OHV        8'h20
`define LSC_RST_CMV        8'h02

// Write masks, reserved bits held at zero
`define LSC_MSK_LFD        8'h07
`define LSC_MSK_AMC        8'h77
`define LSC_MSK_DBI        8'h7F
`define LSC_MSK_LOOP_CURRENT_SETTING       8'h07
`define LSC_MSK_OHV        8'h7F
`define LSC_MSK_CMV        8'h3F

// Field positions
`define LSC_AMC_CM         6
`define LSC_AMC_DIF        5
`define LSC_AMC_SPD        4
`define LSC_AMC_RT         2
`define LSC_AMC_LC         1
`define LSC_AMC_PA         0
`define LSC_OHV_POL        6
`define LSC_LFS_POS        4

// Line-feed state codes
`define LSC_LF_OPEN        3'h0
`define LSC_LF_FWD_ACT     3'h1
`define LSC_LF_REV_ACT     3'h5

// Bus answers
`define LSC_RESP_OKAY      2'h0
`define LSC_RESP_SLVERR    2'h2

// Timing
`define LSC_CLK_NS         10
`define LSC_DBI_STEP_NS    1250000
`define LSC_DBI_STEP_CYC   ((`LSC_DBI_STEP_NS + `LSC_CLK_NS - 1) / `LSC_CLK_NS)

`endif

// *** lsc_pkg.sv ***
// Types shared by the line supervision block
package lsc_pkg;

    typedef struct packed {
        logic       rt_exceed;
        logic       lc_exceed;
        logic       power_alarm;
    } lsc_det_t;

    typedef struct packed {
        logic       common_mode_manual_sel;
        logic       differential_manual_sel;
        logic       speedup_enable;
        logic       cm_force_tip;
        logic       cm_force_ring;
        logic [2:0] loop_current_setting;
        logic       on_hook_polarity;
        logic [5:0] on_hook_voltage_level;
        logic [5:0] common_mode_target;
    } lsc_ctrl_t;

    typedef enum logic {
        LSC_WR_COLLECT,
        LSC_WR_RESP
    } lsc_wr_state_t;

endpackage

// *** lsc_line_supervision.sv ***
// Line supervision control and status registers behind an AXI4-Lite slave
// Summary of operation
// - Common-mode manual bit forces TIP (forward) or RING (reverse) to common-mode target
// - Differential manual bit forces differential voltage to follow on-hook level
// - Bit 4 of control enables automatic speed-up
// - Auto ring-trip bit moves line feed to active on filtered ring trip
// - Auto loop-close bit moves line feed to active on filtered loop closure
// - Auto power-alarm bit moves line feed to open on power alarm
// - Status bit 2 shows the raw combined detector output
// - Raw detector bit reads 0 when threshold exceeded, 1 otherwise
// - Bit 1 shows filtered ring trip; status resets to zero
// - Bit 0 shows filtered loop closure
// - Filtered indicator changes only after raw input steady for debounce interval
// - Loop-closure debounce is 7 bits of 1.25 ms, default 12.5 ms
// - Ring-trip debounce is 7 bits of 1.25 ms, reset 0x0A
// - Three-bit current limit, 20 mA plus 3 mA per code
// - On-hook bit 6 selects polarity, 1 is negative
// - Six-bit on-hook level in 1.5 V steps, register resets to 0x20
// - Line-feed shadow reports the actual state including automatic moves
// - Line-feed states use the documented 3-bit encoding
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "lsc_defs.svh"

module lsc_line_supervision #(
    parameter int unsigned TICK_CYCLES = `LSC_DBI_STEP_CYC
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address
    input  wire logic [11:0]       awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // Write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // Write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // Read address
    input  wire logic [11:0]       araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // Read data
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Analog detectors and power monitor
    input  wire lsc_pkg::lsc_det_t det_in,
    // Line control
    output lsc_pkg::lsc_ctrl_t     line_ctrl,
    output logic [2:0]             linefeed_actual_state
);

    // Decode helpers
    function automatic logic is_mapped(input logic [9:0] idx);
        case (idx)
            `LSC_IDX_LFD, `LSC_IDX_AMC, `LSC_IDX_DET, `LSC_IDX_LCD,
            `LSC_IDX_RTD, `LSC_IDX_LOOP_CURRENT_SETTING, `LSC_IDX_OHV, `LSC_IDX_CMV: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic is_rev(input logic [2:0] st);
        is_rev = st[2] && (st != 3'h4);
    endfunction

    // Registers
    logic [7:0]  lf_req_r;
    logic [2:0]  lf_act_r;
    logic [7:0]  amc_r;
    logic [7:0]  lcd_r;
    logic [7:0]  rtd_r;
    logic [7:0]  loop_current_setting_r;
    logic [7:0]  ohv_r;
    logic [7:0]  cmv_r;
    logic [2:0]  det_r;

    // Write channel
    lsc_pkg::lsc_wr_state_t wst_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [11:0] aw_addr_r;
    logic [7:0]  wd_r;
    logic        wlo_r;
    logic        wr_en;
    logic [9:0]  wr_idx;

    assign awready = (wst_r == lsc_pkg::LSC_WR_COLLECT) && !aw_got_r;
    assign wready  = (wst_r == lsc_pkg::LSC_WR_COLLECT) && !w_got_r;
    assign wr_en   = (wst_r == lsc_pkg::LSC_WR_COLLECT) && aw_got_r && w_got_r;
    assign wr_idx  = aw_addr_r[11:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r     <= lsc_pkg::LSC_WR_COLLECT;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= 12'h000;
            wd_r      <= 8'h00;
            wlo_r     <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `LSC_RESP_OKAY;
        end else begin
            case (wst_r)
                lsc_pkg::LSC_WR_COLLECT: begin
                    if (awvalid && awready) begin
                        aw_got_r  <= 1'b1;
                        aw_addr_r <= awaddr;
                    end
                    if (wvalid && wready) begin
                        w_got_r <= 1'b1;
                        wd_r    <= wdata[7:0];
                        wlo_r   <= wstrb[0];
                    end
                    if (wr_en) begin
                        aw_got_r <= 1'b0;
                        w_got_r  <= 1'b0;
                        bvalid   <= 1'b1;
                        bresp    <= (is_mapped(wr_idx) && aw_addr_r[1:0] == 2'h0) ?
                                    `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
                        wst_r    <= lsc_pkg::LSC_WR_RESP;
                    end
                end
                lsc_pkg::LSC_WR_RESP: begin
                    if (bready) begin
                        bvalid <= 1'b0;
                        wst_r  <= lsc_pkg::LSC_WR_COLLECT;
                    end
                end
                default: wst_r <= lsc_pkg::LSC_WR_COLLECT;
            endcase
        end
    end

    logic wr_ok;
    assign wr_ok = wr_en && wlo_r && (aw_addr_r[1:0] == 2'h0);

    // Software registers, reserved bits masked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lf_req_r <= `LSC_RST_LFD;
            amc_r    <= `LSC_RST_AMC;
            lcd_r    <= `LSC_RST_LCD;
            rtd_r    <= `LSC_RST_RTD;
            loop_current_setting_r   <= `LSC_RST_LOOP_CURRENT_SETTING;
            ohv_r    <= `LSC_RST_OHV;
            cmv_r    <= `LSC_RST_CMV;
        end else if (wr_ok) begin
            case (wr_idx)
                `LSC_IDX_LFD:  lf_req_r <= wd_r & `LSC_MSK_LFD;
                `LSC_IDX_AMC:  amc_r    <= wd_r & `LSC_MSK_AMC;
                `LSC_IDX_LCD:  lcd_r    <= wd_r & `LSC_MSK_DBI;
                `LSC_IDX_RTD:  rtd_r    <= wd_r & `LSC_MSK_DBI;
                `LSC_IDX_LOOP_CURRENT_SETTING: loop_current_setting_r   <= wd_r & `LSC_MSK_LOOP_CURRENT_SETTING;
                `LSC_IDX_OHV:  ohv_r    <= wd_r & `LSC_MSK_OHV;
                `LSC_IDX_CMV:  cmv_r    <= wd_r & `LSC_MSK_CMV;
                default: ;
            endcase
        end
    end

    // Read channel
    logic [7:0] rd_val;
    logic [9:0] rd_idx;
    assign rd_idx  = araddr[11:2];
    assign arready = !rvalid;

    always_comb begin
        case (rd_idx)
            `LSC_IDX_LFD:  rd_val = {1'b0, lf_act_r, 1'b0, lf_req_r[2:0]};
            `LSC_IDX_AMC:  rd_val = amc_r;
            `LSC_IDX_DET:  rd_val = {5'h00, det_r};
            `LSC_IDX_LCD:  rd_val = lcd_r;
            `LSC_IDX_RTD:  rd_val = rtd_r;
            `LSC_IDX_LOOP_CURRENT_SETTING: rd_val = loop_current_setting_r;
            `LSC_IDX_OHV:  rd_val = ohv_r;
            `LSC_IDX_CMV:  rd_val = cmv_r;
            default:       rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `LSC_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            if (is_mapped(rd_idx) && araddr[1:0] == 2'h0) begin
                rdata <= {24'h00_0000, rd_val};
                rresp <= `LSC_RESP_OKAY;
            end else begin
                rdata <= 32'h0000_0000;
                rresp <= `LSC_RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // Detector synchronisers
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       alarm_d_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r   <= 3'h0;
            sync2_r   <= 3'h0;
            alarm_d_r <= 1'b0;
        end else begin
            sync1_r   <= det_in;
            sync2_r   <= sync1_r;
            alarm_d_r <= sync2_r[0];
        end
    end

    logic rt_s;
    logic lc_s;
    logic alarm_evt;
    assign rt_s      = sync2_r[2];
    assign lc_s      = sync2_r[1];
    assign alarm_evt = sync2_r[0] && !alarm_d_r;

    // Debounce step timer
    logic [19:0] tick_cnt_r;
    logic        tick;
    assign tick = (tick_cnt_r == 20'(TICK_CYCLES - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tick_cnt_r <= 20'h0_0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 20'h0_0001;
        end
    end

    // Debounce, index 0 loop closure, 1 ring trip
    logic [1:0] raw_v;
    logic [1:0] filt_r;
    logic [1:0] filt_d_r;
    logic [6:0] dbi_v [2];
    logic [7:0] dcnt_r [2];
    assign raw_v    = {rt_s, lc_s};
    assign dbi_v[0] = lcd_r[6:0];
    assign dbi_v[1] = rtd_r[6:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_r   <= 2'h0;
            filt_d_r <= 2'h0;
            for (int i = 0; i < 2; i++) begin
                dcnt_r[i] <= 8'h00;
            end
        end else begin
            filt_d_r <= filt_r;
            for (int i = 0; i < 2; i++) begin
                if (raw_v[i] == filt_r[i]) begin
                    dcnt_r[i] <= 8'h00;
                end else if (dbi_v[i] == 7'h00 ||
                             (tick && dcnt_r[i] == {1'b0, dbi_v[i]})) begin
                    filt_r[i] <= raw_v[i];
                    dcnt_r[i] <= 8'h00;
                end else if (tick) begin
                    dcnt_r[i] <= dcnt_r[i] + 8'h01;
                end
            end
        end
    end

    // Detect status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_r <= 3'(`LSC_RST_DET);
        end else begin
            det_r <= {~(rt_s | lc_s), filt_r[1], filt_r[0]};
        end
    end

    // Actual line-feed state
    logic rt_rise;
    logic lc_rise;
    logic go_active;
    assign rt_rise   = filt_r[1] && !filt_d_r[1];
    assign lc_rise   = filt_r[0] && !filt_d_r[0];
    assign go_active = (rt_rise && amc_r[`LSC_AMC_RT]) ||
                       (lc_rise && amc_r[`LSC_AMC_LC]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lf_act_r <= `LSC_LF_OPEN;
        end else if (alarm_evt && amc_r[`LSC_AMC_PA]) begin
            lf_act_r <= `LSC_LF_OPEN;
        end else if (go_active) begin
            lf_act_r <= is_rev(lf_act_r) ? `LSC_LF_REV_ACT : `LSC_LF_FWD_ACT;
        end else if (wr_ok && wr_idx == `LSC_IDX_LFD) begin
            lf_act_r <= wd_r[2:0];
        end
    end

    // Line control outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_ctrl             <= '0;
            linefeed_actual_state <= `LSC_LF_OPEN;
        end else begin
            line_ctrl.common_mode_manual_sel  <= amc_r[`LSC_AMC_CM];
            line_ctrl.differential_manual_sel <= amc_r[`LSC_AMC_DIF];
            line_ctrl.speedup_enable          <= amc_r[`LSC_AMC_SPD];
            line_ctrl.cm_force_tip  <= amc_r[`LSC_AMC_CM] && !is_rev(lf_act_r);
            line_ctrl.cm_force_ring <= amc_r[`LSC_AMC_CM] && is_rev(lf_act_r);
            line_ctrl.loop_current_setting    <= loop_current_setting_r[2:0];
            line_ctrl.on_hook_polarity        <= ohv_r[`LSC_OHV_POL];
            line_ctrl.on_hook_voltage_level   <= ohv_r[5:0];
            line_ctrl.common_mode_target      <= cmv_r[5:0];
            linefeed_actual_state             <= lf_act_r;
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence rt_trip_s;
        rt_rise && amc_r[`LSC_AMC_RT] && !(alarm_evt && amc_r[`LSC_AMC_PA]);
    endsequence

    sequence lc_close_s;
        lc_rise && amc_r[`LSC_AMC_LC] && !(alarm_evt && amc_r[`LSC_AMC_PA]);
    endsequence

    cm_tip_force_a: assert property (
        amc_r[`LSC_AMC_CM] && !is_rev(lf_act_r) |=> line_ctrl.cm_force_tip)
        else $error("common mode not forced on tip");

    dif_manual_a: assert property (
        ##1 line_ctrl.differential_manual_sel == $past(amc_r[`LSC_AMC_DIF]))
        else $error("differential select mismatch");

    rt_auto_a: assert property (
        rt_trip_s |=> lf_act_r inside {`LSC_LF_FWD_ACT, `LSC_LF_REV_ACT} ##1
        linefeed_actual_state == $past(lf_act_r))
        else $error("ring trip did not activate line");

    lc_auto_a: assert property (
        lc_close_s |=> lf_act_r inside {`LSC_LF_FWD_ACT, `LSC_LF_REV_ACT})
        else $error("loop closure did not activate line");

    alarm_open_a: assert property (
        alarm_evt && amc_r[`LSC_AMC_PA] |=> lf_act_r == `LSC_LF_OPEN ##1
        linefeed_actual_state == `LSC_LF_OPEN)
        else $error("power alarm did not open line");

    raw_sense_a: assert property (
        (rt_s || lc_s) |=> !det_r[2])
        else $error("raw detector sense wrong");

    debounce_hold_a: assert property (
        $changed(filt_r[1]) |-> $past(tick || rtd_r[6:0] == 7'h00))
        else $error("ring trip filter changed off a step");

    polarity_keep_a: assert property (
        go_active && !(alarm_evt && amc_r[`LSC_AMC_PA]) && is_rev(lf_act_r)
        |=> lf_act_r == `LSC_LF_REV_ACT)
        else $error("reverse polarity lost on auto active");

    reserved_zero_a: assert property (
        $rose(rvalid) |-> rdata[31:8] == 24'h00_0000 && !rdata[7])
        else $error("reserved read bits not zero");

endmodule

// *** line_supervision_control_test.sv ***
// Self-checking testbench of the line supervision register block
`timescale 1ns/1ns
`include "lsc_defs.svh"

module line_supervision_control_test;

    // Clock and reset
    logic                  aclk;
    logic                  aresetn;
    // Register bus
    logic [11:0]           awaddr;
    logic                  awvalid;
    logic                  awready;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  wvalid;
    logic                  wready;
    logic [1:0]            bresp;
    logic                  bvalid;
    logic                  bready;
    logic [11:0]           araddr;
    logic                  arvalid;
    logic                  arready;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  rvalid;
    logic                  rready;
    // Line side
    lsc_pkg::lsc_det_t     det_in;
    lsc_pkg::lsc_ctrl_t    line_ctrl;
    logic [2:0]            linefeed_actual_state;

    int                    fails;
    int                    check_count;

    localparam logic [11:0] A_LFD  = {`LSC_IDX_LFD, 2'b00};
    localparam logic [11:0] A_AMC  = {`LSC_IDX_AMC, 2'b00};
    localparam logic [11:0] A_DET  = {`LSC_IDX_DET, 2'b00};
    localparam logic [11:0] A_LCD  = {`LSC_IDX_LCD, 2'b00};
    localparam logic [11:0] A_RTD  = {`LSC_IDX_RTD, 2'b00};
    localparam logic [11:0] A_LOOP_CURRENT_SETTING = {`LSC_IDX_LOOP_CURRENT_SETTING, 2'b00};
    localparam logic [11:0] A_OHV  = {`LSC_IDX_OHV, 2'b00};
    localparam logic [11:0] A_CMV  = {`LSC_IDX_CMV, 2'h0};
    localparam logic [11:0] A_BAD  = 12'h200;

    lsc_line_supervision #(.TICK_CYCLES(4)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .det_in(det_in), .line_ctrl(line_ctrl),
        .linefeed_actual_state(linefeed_actual_state)
    );

    always #5 aclk = ~aclk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic timed_out();
        fails++;
        $display("wrong value bus wait expected answer seen none");
        print_verdict();
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // One write; waits for the response, returns its code
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw, tb, done;
        int   n;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h000000, d};
        wstrb   <= 4'h1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        done = 1'b0;
        n = 0;
        while (!done && n < 200) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bready && bvalid;
            r  = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                done = 1'b1;
            end
            n++;
        end
        if (!done) timed_out();
    endtask

    // One read; waits for the data, returns data and code
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr, done;
        int   n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        done = 1'b0;
        n = 0;
        while (!done && n < 200) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rready && rvalid;
            d  = rdata;
            r  = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                done = 1'b1;
            end
            n++;
        end
        if (!done) timed_out();
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check("write response", {30'h0, r}, {30'h0, `LSC_RESP_OKAY});
    endtask

    task automatic rd_expect(input string name, input logic [11:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check(name, d, {24'h000000, e});
        check("read response", {30'h0, r}, {30'h0, `LSC_RESP_OKAY});
    endtask

    task automatic set_det(input logic [2:0] v);
        @(posedge aclk);
        det_in <= lsc_pkg::lsc_det_t'(v);
    endtask

    task automatic test_reset_values();
        rd_expect("control", A_AMC, 8'h00);
        rd_expect("status idle", A_DET, 8'h04);
        rd_expect("lc debounce", A_LCD, 8'h0A);
        rd_expect("rt debounce", A_RTD, 8'h0A);
        rd_expect("current limit", A_LOOP_CURRENT_SETTING, 8'h00);
        rd_expect("on hook", A_OHV, 8'h20);
        check("level out", {26'h0, line_ctrl.on_hook_voltage_level}, 32'h20);
        check("polarity out", {31'h0, line_ctrl.on_hook_polarity}, 32'h0);
        rd_expect("cm target", A_CMV, `LSC_RST_CMV);
        check("cm target out", {26'h0, line_ctrl.common_mode_target}, 32'(`LSC_RST_CMV));
    endtask

    task automatic test_fields();
        logic [31:0] d;
        logic [1:0]  r;
        wr(A_AMC, 8'hFF);
        wr(A_LCD, 8'hFF);
        wr(A_RTD, 8'hFF);
        wr(A_LOOP_CURRENT_SETTING, 8'hFF);
        wr(A_OHV, 8'hFF);
        wr(A_DET, 8'hFF);
        wr(A_CMV, 8'hFF);
        rd_expect("control mask", A_AMC, 8'h77);
        rd_expect("cm target mask", A_CMV, 8'h3F);
        rd_expect("lc mask", A_LCD, 8'h7F);
        rd_expect("rt mask", A_RTD, 8'h7F);
        rd_expect("limit mask", A_LOOP_CURRENT_SETTING, 8'h07);
        rd_expect("on hook mask", A_OHV, 8'h7F);
        rd_expect("status ro", A_DET, 8'h04);
        check("cm manual", {31'h0, line_ctrl.common_mode_manual_sel}, 32'h1);
        check("cm tip", {31'h0, line_ctrl.cm_force_tip}, 32'h1);
        check("dif manual", {31'h0, line_ctrl.differential_manual_sel}, 32'h1);
        check("speedup", {31'h0, line_ctrl.speedup_enable}, 32'h1);
        check("limit out", {29'h0, line_ctrl.loop_current_setting}, 32'h7);
        check("polarity set", {31'h0, line_ctrl.on_hook_polarity}, 32'h1);
        check("level max", {26'h0, line_ctrl.on_hook_voltage_level}, 32'h3F);
        check("cm target max", {26'h0, line_ctrl.common_mode_target}, 32'h3F);
        wr(A_LFD, 8'h05);
        wait_cycles(2);
        check("cm ring", {31'h0, line_ctrl.cm_force_ring}, 32'h1);
        check("cm tip off", {31'h0, line_ctrl.cm_force_tip}, 32'h0);
        wr(A_AMC, 8'h00);
        wait_cycles(2);
        check("cm auto", {31'h0, line_ctrl.common_mode_manual_sel}, 32'h0);
        check("dif auto", {31'h0, line_ctrl.differential_manual_sel}, 32'h0);
        check("speedup off", {31'h0, line_ctrl.speedup_enable}, 32'h0);
        axi_wr(A_BAD, 8'h11, r);
        check("bad write", {30'h0, r}, {30'h0, `LSC_RESP_SLVERR});
        axi_wr(A_OHV + 12'h001, 8'h00, r);
        check("unaligned write", {30'h0, r}, {30'h0, `LSC_RESP_SLVERR});
        rd_expect("on hook kept", A_OHV, 8'h7F);
        axi_rd(A_BAD, d, r);
        check("bad read", {30'h0, r}, {30'h0, `LSC_RESP_SLVERR});
        check("bad data", d, 32'h0);
    endtask

    task automatic test_loop_closure();
        wr(A_LCD, 8'h02);
        wr(A_AMC, 8'h02);
        wr(A_LFD, 8'h06);
        set_det(3'b010);
        wait_cycles(4);
        rd_expect("raw before filter", A_DET, 8'h00);
        wait_cycles(20);
        rd_expect("lc filtered", A_DET, 8'h01);
        check("auto reverse", {29'h0, linefeed_actual_state}, 32'h5);
        rd_expect("shadow", A_LFD, 8'h56);
        set_det(3'b000);
        wait_cycles(24);
        rd_expect("lc cleared", A_DET, 8'h04);
    endtask

    task automatic test_ring_trip();
        wr(A_AMC, 8'h00);
        wr(A_RTD, 8'h00);
        wr(A_LFD, 8'h02);
        set_det(3'b100);
        wait_cycles(10);
        rd_expect("rt filtered", A_DET, 8'h02);
        check("manual stays", {29'h0, linefeed_actual_state}, 32'h2);
        set_det(3'b000);
        wait_cycles(10);
        wr(A_AMC, 8'h04);
        set_det(3'b100);
        wait_cycles(10);
        check("auto forward", {29'h0, linefeed_actual_state}, 32'h1);
        set_det(3'b000);
        wait_cycles(10);
    endtask

    task automatic test_power_alarm();
        wr(A_AMC, 8'h01);
        wr(A_LFD, 8'h01);
        set_det(3'b001);
        wait_cycles(8);
        check("alarm open", {29'h0, linefeed_actual_state}, 32'h0);
        rd_expect("alarm shadow", A_LFD, 8'h01);
        set_det(3'b000);
        wr(A_AMC, 8'h00);
        wr(A_LFD, 8'h01);
        set_det(3'b001);
        wait_cycles(8);
        check("alarm manual", {29'h0, linefeed_actual_state}, 32'h1);
        set_det(3'b000);
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        awaddr = 12'h000;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 12'h000;
        arvalid = 1'b0;
        rready = 1'b0;
        det_in = lsc_pkg::lsc_det_t'(3'b000);
        fails = 0;
        check_count = 0;
        wait_cycles(6);
        aresetn <= 1'b1;
        wait_cycles(4);
        test_reset_values();
        test_fields();
        test_loop_closure();
        test_ring_trip();
        test_power_alarm();
        print_verdict();
    end

endmodule
